// ### design/dcl_consts.svh
// timing and framing constants of the c-bit data link port
`ifndef DCL_CONSTS_SVH
`define DCL_CONSTS_SVH
// ============================================================
// clocks
`define DCL_CLK_NS 40
`define DCL_CLK_KHZ 25000
`define DCL_OH_KHZ 526
`define DCL_OH_HALF_CYC ((`DCL_CLK_KHZ + `DCL_OH_KHZ) / (2 * `DCL_OH_KHZ))
// ============================================================
// overhead frame
`define DCL_OH_SLOTS 56
`define DCL_CBIT_SLOT_1 34
`define DCL_CBIT_SLOT_2 36
`define DCL_CBIT_SLOT_3 38
// ============================================================
// link bit clock
`define DCL_LINK_LOW_NS 1900
`define DCL_LINK_LOW_CYC ((`DCL_LINK_LOW_NS + `DCL_CLK_NS - 1) / `DCL_CLK_NS)
// ============================================================
// message end input
`define DCL_EOM_LATE_US 210
`define DCL_EOM_LATE_CYC (`DCL_EOM_LATE_US * 1000 / `DCL_CLK_NS)
`define DCL_EOM_PULSE_CYC 8
`endif

// ### design/dcl_pkg.sv
// types shared by both ends of the c-bit data link port
package dcl_pkg;
  // ============================================================
  // configuration, active_high bits: 0 = active low
  typedef struct packed {
    logic rx_ext;
    logic tx_ext;
    logic cparity_en;
    logic rx_eom_act_high;
    logic rx_irq_act_high;
    logic tx_udr_act_high;
    logic tx_irq_act_high;
  } dcl_cfg_t;
  // ============================================================
  // host message end pulser
  typedef enum logic {DCL_EOM_IDLE, DCL_EOM_DRIVE} dcl_eom_state_t;
endpackage : dcl_pkg

// ### design/dcl_link_if.sv
// pin level link between the device end and the host end
`timescale 1ns/1ps
interface dcl_link_if;
  logic rx_sig_o;
  logic rx_sig_oe;
  logic rx_clk_o;
  logic rx_clk_oe;
  logic tx_sig_dev_o;
  logic tx_sig_dev_oe;
  logic tx_sig_host_o;
  logic tx_sig_host_oe;
  logic tx_clk_o;
  logic tx_clk_oe;
  logic tx_eom_o;
  logic rx_sig;
  logic rx_clk;
  logic tx_sig;
  logic tx_clk;
  // released pin settles at the inactive level of its driver
  assign rx_sig = rx_sig_oe ? rx_sig_o : ~rx_sig_o;
  assign rx_clk = rx_clk_oe ? rx_clk_o : ~rx_clk_o;
  assign tx_clk = tx_clk_oe ? tx_clk_o : ~tx_clk_o;
  assign tx_sig = tx_sig_dev_oe ? tx_sig_dev_o :
                  (tx_sig_host_oe ? tx_sig_host_o : ~tx_sig_dev_o);
  modport device (
    output rx_sig_o, rx_sig_oe, rx_clk_o, rx_clk_oe,
    output tx_sig_dev_o, tx_sig_dev_oe, tx_clk_o, tx_clk_oe,
    input tx_sig, tx_eom_o
  );
  modport host (
    output tx_sig_host_o, tx_sig_host_oe, tx_eom_o,
    input rx_sig, rx_clk, tx_sig, tx_clk
  );
endinterface : dcl_link_if

// ### design/dcl_host.sv
// host end: external hdlc controller or dma controller of the link
`timescale 1ns/1ps
`include "dcl_consts.svh"
module dcl_host #(
  parameter int EOM_LATE_CYC = `DCL_EOM_LATE_CYC
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire dcl_pkg::dcl_cfg_t cfg_in,
  input wire logic tx_bit_in,
  input wire logic tx_eom_req_in,
  output logic rx_bit_out,
  output logic rx_bit_valid_out,
  output logic rx_eom_seen_out,
  output logic rx_irq_seen_out,
  output logic tx_bit_taken_out,
  output logic tx_udr_seen_out,
  output logic tx_irq_seen_out,
  output logic tx_eom_late_out,
  dcl_link_if.host link
);
  import dcl_pkg::*;
  localparam int TW = $clog2(EOM_LATE_CYC + 1);
  localparam logic [TW-1:0] LATE = TW'(EOM_LATE_CYC);

  // ============================================================
  // pin synchronisers: rx_sig, rx_clk, tx_sig, tx_clk
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [1:0] clk_prev;
  logic rx_rise;
  logic tx_fall;
  assign rx_rise = pin_sync[2] & ~clk_prev[0];
  assign tx_fall = ~pin_sync[0] & clk_prev[1];

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // released pins read high: no false edge or flag after reset
      pin_meta <= '1;
      pin_sync <= '1;
      clk_prev <= '1;
    end else begin
      pin_meta <= {link.rx_sig, link.rx_clk, link.tx_sig, link.tx_clk};
      pin_sync <= pin_meta;
      clk_prev <= {pin_sync[0], pin_sync[2]};
    end
  end

  // ============================================================
  // serial data and flags
  logic next_rx_bit, next_rx_valid, next_tx_o, next_tx_oe, next_taken;
  logic next_rx_eom, next_rx_irq, next_udr, next_irq;

  always_comb begin
    next_rx_bit = rx_bit_out;
    next_rx_valid = 1'b0;
    next_tx_o = link.tx_sig_host_o;
    next_tx_oe = cfg_in.tx_ext;
    next_taken = 1'b0;
    if (rx_rise && cfg_in.rx_ext) begin
      next_rx_bit = pin_sync[3];
      next_rx_valid = 1'b1;
    end
    if (tx_fall && cfg_in.tx_ext) begin
      next_tx_o = tx_bit_in;
      next_taken = 1'b1;
    end
    next_rx_eom = ~cfg_in.rx_ext & (pin_sync[3] == cfg_in.rx_eom_act_high);
    next_rx_irq = ~cfg_in.rx_ext & (pin_sync[2] == cfg_in.rx_irq_act_high);
    next_udr = ~cfg_in.tx_ext & (pin_sync[1] == cfg_in.tx_udr_act_high);
    next_irq = ~cfg_in.tx_ext & (pin_sync[0] == cfg_in.tx_irq_act_high);
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_bit_out <= 1'b0;
      rx_bit_valid_out <= 1'b0;
      link.tx_sig_host_o <= 1'b0;
      link.tx_sig_host_oe <= 1'b0;
      tx_bit_taken_out <= 1'b0;
      rx_eom_seen_out <= 1'b0;
      rx_irq_seen_out <= 1'b0;
      tx_udr_seen_out <= 1'b0;
      tx_irq_seen_out <= 1'b0;
    end else begin
      rx_bit_out <= next_rx_bit;
      rx_bit_valid_out <= next_rx_valid;
      link.tx_sig_host_o <= next_tx_o;
      link.tx_sig_host_oe <= next_tx_oe;
      tx_bit_taken_out <= next_taken;
      rx_eom_seen_out <= next_rx_eom;
      rx_irq_seen_out <= next_rx_irq;
      tx_udr_seen_out <= next_udr;
      tx_irq_seen_out <= next_irq;
    end
  end

  // ============================================================
  // message end pulse and its deadline after the transmit interrupt
  dcl_eom_state_t eom_st, next_eom_st;
  logic [3:0] eom_cnt, next_eom_cnt;
  logic next_eom_o;
  logic [TW-1:0] timer, next_timer;
  logic armed, next_armed;
  logic next_late;

  always_comb begin
    next_eom_st = eom_st;
    next_eom_cnt = eom_cnt;
    next_eom_o = 1'b0;
    next_timer = (timer == LATE) ? timer : timer + TW'(1);
    next_armed = armed;
    next_late = tx_eom_late_out;
    if (next_irq && !tx_irq_seen_out) begin
      next_timer = '0;
      next_armed = 1'b1;
    end
    case (eom_st)
      DCL_EOM_IDLE: begin
        if (tx_eom_req_in) begin
          next_eom_st = DCL_EOM_DRIVE;
          next_eom_cnt = 4'(`DCL_EOM_PULSE_CYC - 1);
          next_eom_o = 1'b1;
          next_late = armed && (timer == LATE);
          next_armed = 1'b0;
        end
      end
      DCL_EOM_DRIVE: begin
        next_eom_o = (eom_cnt != '0);
        next_eom_cnt = eom_cnt - 4'd1;
        if (eom_cnt == '0) begin
          next_eom_st = DCL_EOM_IDLE;
        end
      end
      default: next_eom_st = DCL_EOM_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      eom_st <= DCL_EOM_IDLE;
      eom_cnt <= '0;
      link.tx_eom_o <= 1'b0;
      timer <= '0;
      armed <= 1'b0;
      tx_eom_late_out <= 1'b0;
    end else begin
      eom_st <= next_eom_st;
      eom_cnt <= next_eom_cnt;
      link.tx_eom_o <= next_eom_o;
      timer <= next_timer;
      armed <= next_armed;
      tx_eom_late_out <= next_late;
    end
  end
endmodule : dcl_host

// ### design/dcl_device.sv
// device end of the ds3 c-bit maintenance data link pins
`timescale 1ns/1ps
`include "dcl_consts.svh"
// ============================================================
// What this block does
// - rx external mode: pin carries subframe-5 c-bits
// - rx serial data changes on link clock fall
// - rx internal mode: pin flags message end/overflow
// - rx message-end pin updates on overhead fall
// - rx message-end holds until status read
// - dma systems wire message-end active-low open-drain
// - tx external mode: pin is serial input
// - tx serial input ignored without c-bit parity
// - tx serial input sampled on link clock rise
// - tx internal mode: underrun flag, cleared by write
// - underrun and tx irq: open-drain, selectable polarity
// - after reset tx data pin is external input
// - after reset tx clock pin is interrupt
// - software sets tx select after reset
// - tx link clock 28.2 khz, low 1.9us min
// - tx irq rises when last byte written
// - config or data write answers tx irq
// - message-end pin sets message end bit
// - message-end pin due within 210 us
// - message-end pin ignored with nothing pending
// - rx link clock 28.2 khz, low 1.9us min
// - rx irq pin cleared by status read
module dcl_device (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire dcl_pkg::dcl_cfg_t cfg_in,
  input wire logic cfg_write_in,
  input wire logic rx_cbit_in,
  input wire logic rx_msg_end_evt_in,
  input wire logic rx_irq_evt_in,
  input wire logic rx_status_read_in,
  input wire logic tx_underrun_evt_in,
  input wire logic tx_status_write_in,
  input wire logic tx_last_byte_evt_in,
  input wire logic tx_config_write_in,
  input wire logic tx_config_eom_in,
  input wire logic tx_data_write_in,
  input wire logic tx_data_pending_in,
  input wire logic tx_message_done_in,
  output logic rx_overhead_clock_out,
  output logic tx_overhead_clock_out,
  output logic overhead_frame_out,
  output logic tx_cbit_out,
  output logic tx_cbit_valid_out,
  output logic message_end_bit_out,
  dcl_link_if.device link
);
  import dcl_pkg::*;

  function automatic logic is_cbit_slot(input logic [5:0] s);
    return (s == 6'(`DCL_CBIT_SLOT_1)) || (s == 6'(`DCL_CBIT_SLOT_2)) ||
           (s == 6'(`DCL_CBIT_SLOT_3));
  endfunction : is_cbit_slot

  // open-drain flag: {level, enable}; drives only while asserted
  function automatic logic [1:0] od_flag(input logic asserted, input logic act_high);
    return {act_high, asserted};
  endfunction : od_flag

  // ============================================================
  // overhead clock, slot counter and link bit clock
  logic [4:0] div, next_div;
  logic oh_clk, next_oh_clk;
  logic [5:0] slot, next_slot;
  logic link_clk, next_link_clk;
  logic [5:0] low_cnt, next_low_cnt;
  logic [1:0] rise_dly, next_rise_dly;
  logic next_frame;
  logic oh_fall;

  always_comb begin
    next_div = div + 5'd1;
    next_oh_clk = oh_clk;
    next_slot = slot;
    next_link_clk = link_clk;
    next_low_cnt = (low_cnt >= 6'(`DCL_LINK_LOW_CYC - 1)) ? low_cnt : low_cnt + 6'd1;
    next_rise_dly = {rise_dly[0], 1'b0};
    next_frame = overhead_frame_out;
    oh_fall = 1'b0;
    if (div == 5'(`DCL_OH_HALF_CYC - 1)) begin
      next_div = '0;
      next_oh_clk = ~oh_clk;
      oh_fall = oh_clk;
    end
    if (oh_fall) begin
      next_slot = (slot == 6'(`DCL_OH_SLOTS - 1)) ? 6'd0 : slot + 6'd1;
      next_frame = (next_slot == 6'd0);
      if (is_cbit_slot(next_slot)) begin
        next_link_clk = 1'b0;
        next_low_cnt = '0;
      end else if (low_cnt >= 6'(`DCL_LINK_LOW_CYC - 1)) begin
        next_link_clk = 1'b1;
        next_rise_dly[0] = ~link_clk;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div <= '0;
      oh_clk <= 1'b0;
      slot <= '0;
      link_clk <= 1'b1;
      low_cnt <= '0;
      rise_dly <= '0;
      overhead_frame_out <= 1'b0;
      rx_overhead_clock_out <= 1'b0;
      tx_overhead_clock_out <= 1'b0;
    end else begin
      div <= next_div;
      oh_clk <= next_oh_clk;
      slot <= next_slot;
      link_clk <= next_link_clk;
      low_cnt <= next_low_cnt;
      rise_dly <= next_rise_dly;
      overhead_frame_out <= next_frame;
      rx_overhead_clock_out <= next_oh_clk;
      tx_overhead_clock_out <= next_oh_clk;
    end
  end

  // ============================================================
  // configuration and pin function selection
  dcl_cfg_t cfg, next_cfg;
  logic sel_written, next_sel_written;
  logic data_ext;
  logic clk_ext;

  always_comb begin
    next_cfg = cfg_write_in ? cfg_in : cfg;
    next_sel_written = sel_written | cfg_write_in;
  end

  assign data_ext = sel_written ? cfg.tx_ext : 1'b1;
  assign clk_ext = sel_written & cfg.tx_ext;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg <= '0;
      sel_written <= 1'b0;
    end else begin
      cfg <= next_cfg;
      sel_written <= next_sel_written;
    end
  end

  // ============================================================
  // pin synchronisers
  logic tx_sig_meta, tx_sig_sync;
  logic eom_meta, eom_sync, eom_prev;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_sig_meta <= 1'b0;
      tx_sig_sync <= 1'b0;
      eom_meta <= 1'b0;
      eom_sync <= 1'b0;
      eom_prev <= 1'b0;
    end else begin
      tx_sig_meta <= link.tx_sig;
      tx_sig_sync <= tx_sig_meta;
      eom_meta <= link.tx_eom_o;
      eom_sync <= eom_meta;
      eom_prev <= eom_sync;
    end
  end

  // ============================================================
  // sticky flags, message end bit and tx serial capture
  logic rx_eom, next_rx_eom;
  logic rx_irq, next_rx_irq;
  logic tx_udr, next_tx_udr;
  logic tx_irq, next_tx_irq;
  logic next_msg_end;
  logic next_tx_cbit, next_tx_cbit_valid;
  logic eom_pin_set;

  always_comb begin
    eom_pin_set = eom_sync & ~eom_prev & tx_data_pending_in;
    // set wins over clear on every flag
    next_rx_eom = rx_msg_end_evt_in | (rx_eom & ~rx_status_read_in);
    next_rx_irq = rx_irq_evt_in | (rx_irq & ~rx_status_read_in);
    next_tx_udr = tx_underrun_evt_in | (tx_udr & ~tx_status_write_in);
    next_tx_irq = tx_last_byte_evt_in |
                  (tx_irq & ~(tx_config_write_in | tx_data_write_in));
    next_msg_end = eom_pin_set | (tx_config_write_in & tx_config_eom_in) |
                   (message_end_bit_out & ~tx_message_done_in);
    next_tx_cbit = tx_cbit_out;
    next_tx_cbit_valid = 1'b0;
    if (rise_dly[1] && data_ext && cfg.cparity_en) begin
      next_tx_cbit = tx_sig_sync;
      next_tx_cbit_valid = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_eom <= 1'b0;
      rx_irq <= 1'b0;
      tx_udr <= 1'b0;
      tx_irq <= 1'b0;
      message_end_bit_out <= 1'b0;
      tx_cbit_out <= 1'b0;
      tx_cbit_valid_out <= 1'b0;
    end else begin
      rx_eom <= next_rx_eom;
      rx_irq <= next_rx_irq;
      tx_udr <= next_tx_udr;
      tx_irq <= next_tx_irq;
      message_end_bit_out <= next_msg_end;
      tx_cbit_out <= next_tx_cbit;
      tx_cbit_valid_out <= next_tx_cbit_valid;
    end
  end

  // ============================================================
  // shared pin drivers
  logic [1:0] next_rx_sig, next_rx_clk, next_tx_sig, next_tx_clk;

  always_comb begin
    next_rx_sig = {link.rx_sig_o, link.rx_sig_oe};
    next_rx_clk = {link.rx_clk_o, link.rx_clk_oe};
    if (cfg.rx_ext) begin
      next_rx_clk = {next_link_clk, 1'b1};
      next_rx_sig[0] = 1'b1;
      if (oh_fall && is_cbit_slot(next_slot)) begin
        next_rx_sig[1] = rx_cbit_in;
      end
    end else if (oh_fall) begin
      next_rx_sig = od_flag(rx_eom, cfg.rx_eom_act_high);
      next_rx_clk = od_flag(rx_irq, cfg.rx_irq_act_high);
    end
    if (data_ext) begin
      next_tx_sig = 2'b00;
    end else begin
      next_tx_sig = od_flag(tx_udr, cfg.tx_udr_act_high);
    end
    if (clk_ext) begin
      next_tx_clk = {next_link_clk, 1'b1};
    end else begin
      next_tx_clk = od_flag(tx_irq, cfg.tx_irq_act_high);
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {link.rx_sig_o, link.rx_sig_oe} <= 2'b00;
      {link.rx_clk_o, link.rx_clk_oe} <= 2'b00;
      {link.tx_sig_dev_o, link.tx_sig_dev_oe} <= 2'b00;
      {link.tx_clk_o, link.tx_clk_oe} <= 2'b00;
    end else begin
      {link.rx_sig_o, link.rx_sig_oe} <= next_rx_sig;
      {link.rx_clk_o, link.rx_clk_oe} <= next_rx_clk;
      {link.tx_sig_dev_o, link.tx_sig_dev_oe} <= next_tx_sig;
      {link.tx_clk_o, link.tx_clk_oe} <= next_tx_clk;
    end
  end
endmodule : dcl_device

// ### dv/dcl_link_chk.sv
// assertions on the pins between the device end and the host end
`timescale 1ns/1ps
module dcl_link_chk (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic rx_sig_o,
  input wire logic rx_sig_oe,
  input wire logic rx_clk_o,
  input wire logic rx_clk_oe,
  input wire logic tx_sig_dev_o,
  input wire logic tx_sig_dev_oe,
  input wire logic tx_sig_host_o,
  input wire logic tx_sig_host_oe,
  input wire logic tx_clk_o,
  input wire logic tx_clk_oe,
  input wire logic tx_eom_o
);
  // ============================================================
  // cycles since the last rx link clock fall
  logic [11:0] gap;
  logic gap_seen;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gap <= 12'h000;
      gap_seen <= 1'b0;
    end else begin
      gap <= $fell(rx_clk_o) ? 12'h001 : ((gap == 12'hfff) ? gap : gap + 12'h001);
      gap_seen <= rx_clk_oe && (gap_seen || $fell(rx_clk_o));
    end
  end
  // ============================================================
  // pin rules
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  reset_pins_a: assert property ($rose(rst_b_in) |-> !tx_sig_dev_oe && !tx_clk_oe)
    else $error("tx pins not in default function after reset");
  rx_clk_low_a: assert property ($fell(rx_clk_o) && rx_clk_oe && $past(rx_clk_oe) |->
    ##47 (!rx_clk_o || !rx_clk_oe) ##1 (rx_clk_o || !rx_clk_oe))
    else $error("rx link clock low time wrong");
  tx_clk_low_a: assert property ($fell(tx_clk_o) && tx_clk_oe && $past(tx_clk_oe) |->
    ##47 (!tx_clk_o || !tx_clk_oe) ##1 (tx_clk_o || !tx_clk_oe))
    else $error("tx link clock low time wrong");
  rx_data_edge_a: assert property (rx_sig_oe && $past(rx_sig_oe) && rx_clk_oe &&
    $changed(rx_sig_o) |-> $fell(rx_clk_o))
    else $error("rx serial data changed off the link clock fall");
  rx_frame_gap_a: assert property ($fell(rx_clk_o) && rx_clk_oe && gap_seen |->
    gap == 12'h060 || gap == 12'h9c0)
    else $error("rx link clock falls not three per frame");
  udr_level_a: assert property (tx_sig_dev_oe && $past(tx_sig_dev_oe) |-> $stable(tx_sig_dev_o))
    else $error("underrun pin level moved while asserted");
  no_contention_a: assert property (!(tx_sig_dev_oe && tx_sig_host_oe))
    else $error("both ends drive the tx data pin");
  tx_data_hold_a: assert property (tx_sig_host_oe && tx_clk_oe && $rose(tx_clk_o) |->
    $stable(tx_sig_host_o)[*3])
    else $error("tx serial data moved around the link clock rise");
  eom_pulse_a: assert property ($rose(tx_eom_o) |-> tx_eom_o[*8] ##1 !tx_eom_o)
    else $error("message end pulse width wrong");
endmodule : dcl_link_chk

// ### dv/ds3_cbit_data_link_port_bench.sv
// self-checking bench joining the device end and the host end
`timescale 1ns/1ps
`include "dcl_consts.svh"
module ds3_cbit_data_link_port_bench;
  import dcl_pkg::*;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  dcl_cfg_t cfg = '0;
  logic [10:0] pul = 11'h000;
  logic rx_cbit = 1'b0;
  logic tx_bit = 1'b0;
  logic cfg_eom = 1'b0;
  logic pending = 1'b0;
  wire rx_bit;
  wire tx_cbit;
  wire [7:0] obs;
  wire oh_rx;
  wire oh_tx;
  wire oh_frame;
  wire taken;
  int err_count = 0;
  int total_checks = 0;
  dcl_link_if link ();
  always #20 clock_in = ~clock_in;
  // ============================================================
  // both ends and the checker
  dcl_device u_dcl_device (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .cfg_in(cfg), .cfg_write_in(pul[0]),
    .rx_cbit_in(rx_cbit), .rx_msg_end_evt_in(pul[1]), .rx_irq_evt_in(pul[2]),
    .rx_status_read_in(pul[3]), .tx_underrun_evt_in(pul[4]), .tx_status_write_in(pul[5]),
    .tx_last_byte_evt_in(pul[6]), .tx_config_write_in(pul[7]), .tx_config_eom_in(cfg_eom),
    .tx_data_write_in(pul[8]), .tx_data_pending_in(pending), .tx_message_done_in(pul[9]),
    .rx_overhead_clock_out(oh_rx), .tx_overhead_clock_out(oh_tx), .overhead_frame_out(oh_frame),
    .tx_cbit_out(tx_cbit), .tx_cbit_valid_out(obs[5]), .message_end_bit_out(obs[6]),
    .link(link.device));
  dcl_host #(.EOM_LATE_CYC(50)) u_dcl_host (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .cfg_in(cfg), .tx_bit_in(tx_bit),
    .tx_eom_req_in(pul[10]), .rx_bit_out(rx_bit), .rx_bit_valid_out(obs[0]),
    .rx_eom_seen_out(obs[1]), .rx_irq_seen_out(obs[2]), .tx_bit_taken_out(taken),
    .tx_udr_seen_out(obs[3]), .tx_irq_seen_out(obs[4]), .tx_eom_late_out(obs[7]),
    .link(link.host));
  dcl_link_chk u_dcl_link_chk (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .rx_sig_o(link.rx_sig_o),
    .rx_sig_oe(link.rx_sig_oe), .rx_clk_o(link.rx_clk_o), .rx_clk_oe(link.rx_clk_oe),
    .tx_sig_dev_o(link.tx_sig_dev_o), .tx_sig_dev_oe(link.tx_sig_dev_oe),
    .tx_sig_host_o(link.tx_sig_host_o), .tx_sig_host_oe(link.tx_sig_host_oe),
    .tx_clk_o(link.tx_clk_o), .tx_clk_oe(link.tx_clk_oe), .tx_eom_o(link.tx_eom_o));
  // ============================================================
  // shared tasks
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic check(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic pulse(input int i);
    @(posedge clock_in);
    pul[i] <= 1'b1;
    @(posedge clock_in);
    pul[i] <= 1'b0;
  endtask : pulse
  task automatic wait_sig(input int idx, input logic val, input int bound);
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      #1;
      n++;
    end while (obs[idx] !== val && n < bound);
    check(obs[idx], val);
    if (obs[idx] !== val) give_verdict();
  endtask : wait_sig
  task automatic set_cfg(input dcl_cfg_t c);
    @(posedge clock_in);
    cfg <= c;
    pulse(0);
  endtask : set_cfg
  // ============================================================
  // scenarios
  task automatic reset_case();
    @(posedge clock_in);
    #1;
    check(link.tx_sig_dev_oe, 1'b0);
    check(link.tx_clk_oe, 1'b0);
  endtask : reset_case
  task automatic clock_case();
    int n;
    int hi_rx;
    int hi_tx;
    n = 0;
    hi_rx = 0;
    hi_tx = 0;
    while (oh_frame !== 1'b1 && n < 3000) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    check(oh_frame, 1'b1);
    if (oh_frame !== 1'b1) give_verdict();
    n = 0;
    while (oh_frame === 1'b1 && n < 100) begin
      if (oh_rx === 1'b1) hi_rx++;
      if (oh_tx === 1'b1) hi_tx++;
      @(posedge clock_in);
      #1;
      n++;
    end
    check(n == 2 * `DCL_OH_HALF_CYC, 1'b1);
    check(hi_rx == `DCL_OH_HALF_CYC, 1'b1);
    check(hi_tx == `DCL_OH_HALF_CYC, 1'b1);
  endtask : clock_case
  task automatic ext_case();
    logic hit;
    logic took;
    set_cfg(dcl_cfg_t'(7'h70));
    @(posedge clock_in);
    #1;
    check(link.tx_clk_oe, 1'b1);
    for (int k = 1; k >= 0; k--) begin
      @(posedge clock_in);
      rx_cbit <= k[0];
      tx_bit <= k[0];
      wait_sig(0, 1'b1, 3000);
      wait_sig(0, 1'b1, 3000);
      check(rx_bit, k[0]);
      wait_sig(5, 1'b1, 3000);
      wait_sig(5, 1'b1, 3000);
      check(tx_cbit, k[0]);
    end
    set_cfg(dcl_cfg_t'(7'h60));
    hit = 1'b0;
    took = 1'b0;
    repeat (3000) begin
      @(posedge clock_in);
      #1;
      if (obs[5] === 1'b1) hit = 1'b1;
      if (taken === 1'b1) took = 1'b1;
    end
    check(hit, 1'b0);
    check(took, 1'b1);
  endtask : ext_case
  task automatic flag_case(input logic p);
    set_cfg(dcl_cfg_t'({3'b001, {4{p}}}));
    pulse(1);
    wait_sig(1, 1'b1, 120);
    repeat (100) @(posedge clock_in);
    #1;
    check(obs[1], 1'b1);
    check(link.rx_sig_o, p);
    check(link.rx_sig_oe, 1'b1);
    pulse(3);
    wait_sig(1, 1'b0, 120);
    pulse(2);
    wait_sig(2, 1'b1, 120);
    pulse(3);
    wait_sig(2, 1'b0, 120);
    pulse(4);
    wait_sig(3, 1'b1, 20);
    check(link.tx_sig_dev_o, p);
    pulse(5);
    wait_sig(3, 1'b0, 20);
    pulse(6);
    wait_sig(4, 1'b1, 20);
    pulse(8);
    wait_sig(4, 1'b0, 20);
    pulse(6);
    wait_sig(4, 1'b1, 20);
    pulse(7);
    wait_sig(4, 1'b0, 20);
  endtask : flag_case
  task automatic eom_case();
    set_cfg(dcl_cfg_t'(7'h10));
    pulse(10);
    repeat (20) @(posedge clock_in);
    #1;
    check(obs[6], 1'b0);
    @(posedge clock_in);
    pending <= 1'b1;
    pulse(6);
    wait_sig(4, 1'b1, 20);
    repeat (60) @(posedge clock_in);
    pulse(10);
    wait_sig(6, 1'b1, 20);
    check(obs[7], 1'b1);
    pulse(9);
    wait_sig(6, 1'b0, 5);
    pulse(8);
    wait_sig(4, 1'b0, 20);
    pulse(6);
    wait_sig(4, 1'b1, 20);
    pulse(10);
    wait_sig(6, 1'b1, 20);
    check(obs[7], 1'b0);
    pulse(9);
    wait_sig(6, 1'b0, 5);
    @(posedge clock_in);
    cfg_eom <= 1'b1;
    pulse(7);
    wait_sig(6, 1'b1, 5);
  endtask : eom_case
  // ============================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clock_in);
    rst_b_in <= 1'b1;
    reset_case();
    clock_case();
    ext_case();
    flag_case(1'b0);
    flag_case(1'b1);
    eom_case();
    give_verdict();
  end
endmodule : ds3_cbit_data_link_port_bench
